// ### src/pmcs_pkg.sv
package pmcs_pkg;

  // -----------------------------------------------------------------
  // Register map
  // -----------------------------------------------------------------
  localparam logic [3:0] SMC_OFFSET    = 4'h0;
  localparam int         SMC_HIGH_LOW_CLOCK_SELECT_BIT = 0;
  localparam int         SMC_IDLE_BIT  = 1;
  localparam int         SMC_FRDY_BIT  = 2;
  localparam int         SMC_SRDY_BIT  = 3;
  localparam int         SMC_QWAKE_BIT = 4;
  localparam int         SMC_CKS_LSB   = 5;
  localparam int         SMC_CKS_MSB   = 7;

  // Values after reset
  localparam logic [2:0] CKS_RESET     = 3'h0;
  localparam logic       QWAKE_RESET   = 1'b0;
  localparam logic       IDLE_RESET    = 1'b1;
  localparam logic       HIGH_LOW_CLOCK_SELECT_RESET   = 1'b1;

  // Lowest divider code that selects the high-speed clock
  localparam logic [2:0] CKS_FIRST_DIV = 3'h2;
  localparam logic [3:0] CKS_SHIFT_TOP = 4'h8;

  // -----------------------------------------------------------------
  // Stabilisation counts, in oscillator cycles
  // -----------------------------------------------------------------
  localparam int FAST_XTAL_CYCLES = 128;
  localparam int FAST_RC_CYCLES   = 16;
  localparam int SLOW_XTAL_CYCLES = 128;
  localparam int SLOW_RC_CYCLES   = 2;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_DEEP,
    ST_LIGHT,
    ST_IDLE_LOW,
    ST_IDLE_FULL,
    ST_WAKE,
    ST_QUICK
  } pmcs_state_e;

endpackage

// ### src/pmcs_stab_cnt.sv
`timescale 1ns/10ps
module pmcs_stab_cnt #(
  parameter int CNT_W = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             osc_on,
  input  wire logic             osc_tick,
  input  wire logic [CNT_W-1:0] target,
  output logic                  ready
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             rdy_q;
  logic             rdy_d;

  // Counts oscillator cycles since the oscillator was started
  always_comb begin
    cnt_d = cnt_q;
    rdy_d = rdy_q;
    if (!osc_on) begin
      cnt_d = '0;
      rdy_d = 1'b0;
    end else if (osc_tick && !rdy_q) begin
      cnt_d = cnt_q + 1'b1;
      rdy_d = (cnt_d >= target);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end

  assign ready = rdy_q;

endmodule

// ### src/pmcs_top.sv
`timescale 1ns/10ps
module pmcs_top #(
  parameter int CNT_W        = 8,
  parameter int FAST_XTAL_CN = pmcs_pkg::FAST_XTAL_CYCLES,
  parameter int FAST_RC_CN   = pmcs_pkg::FAST_RC_CYCLES,
  parameter int SLOW_XTAL_CN = pmcs_pkg::SLOW_XTAL_CYCLES,
  parameter int SLOW_RC_CN   = pmcs_pkg::SLOW_RC_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       halt_req,
  input  wire logic       wake_req,
  input  wire logic       low_voltage_detect_enable,
  input  wire logic       system_osc_keep_on,
  input  wire logic       cfg_fast_is_crystal,
  input  wire logic       cfg_slow_is_crystal,
  input  wire logic       cfg_wdt_enable,
  input  wire logic       cfg_wdt_on_slow,
  input  wire logic       fast_osc_tick,
  input  wire logic       slow_osc_tick,
  output logic            fast_osc_enable,
  output logic            slow_osc_enable,
  output logic            slow_periph_clk_enable,
  output logic            wdt_run,
  output logic            cpu_run,
  output logic            sys_clk_tick,
  output logic      [2:0] power_state
);

  // -----------------------------------------------------------------
  // Register file
  // -----------------------------------------------------------------
  logic [2:0] clock_divider_select_q, clock_divider_select_d;
  logic       quick_wake_enable_q,    quick_wake_enable_d;
  logic       idle_on_halt_q,         idle_on_halt_d;
  logic       high_low_clock_select_q, high_low_clock_select_d;
  logic [7:0] rdata_q,                rdata_d;
  logic       slow_osc_ready;
  logic       fast_osc_ready;
  logic [7:0] smc_value;
  logic       hit;

  assign hit = (reg_addr == pmcs_pkg::SMC_OFFSET);

  always_comb begin
    smc_value = 8'h00;
    smc_value[pmcs_pkg::SMC_CKS_MSB:pmcs_pkg::SMC_CKS_LSB] = clock_divider_select_q;
    smc_value[pmcs_pkg::SMC_QWAKE_BIT] = quick_wake_enable_q;
    smc_value[pmcs_pkg::SMC_SRDY_BIT]  = slow_osc_ready;
    smc_value[pmcs_pkg::SMC_FRDY_BIT]  = fast_osc_ready;
    smc_value[pmcs_pkg::SMC_IDLE_BIT]  = idle_on_halt_q;
    smc_value[pmcs_pkg::SMC_HIGH_LOW_CLOCK_SELECT_BIT] = high_low_clock_select_q;
  end

  // Ready flags are read-only; writes to those bits are dropped
  always_comb begin
    clock_divider_select_d  = clock_divider_select_q;
    quick_wake_enable_d     = quick_wake_enable_q;
    idle_on_halt_d          = idle_on_halt_q;
    high_low_clock_select_d = high_low_clock_select_q;
    rdata_d                 = 8'h00;
    if (reg_wr && hit) begin
      clock_divider_select_d  = reg_wdata[pmcs_pkg::SMC_CKS_MSB:pmcs_pkg::SMC_CKS_LSB];
      quick_wake_enable_d     = reg_wdata[pmcs_pkg::SMC_QWAKE_BIT];
      idle_on_halt_d          = reg_wdata[pmcs_pkg::SMC_IDLE_BIT];
      high_low_clock_select_d = reg_wdata[pmcs_pkg::SMC_HIGH_LOW_CLOCK_SELECT_BIT];
    end
    if (reg_rd && hit) begin
      rdata_d = smc_value;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clock_divider_select_q  <= pmcs_pkg::CKS_RESET;
      quick_wake_enable_q     <= pmcs_pkg::QWAKE_RESET;
      idle_on_halt_q          <= pmcs_pkg::IDLE_RESET;
      high_low_clock_select_q <= pmcs_pkg::HIGH_LOW_CLOCK_SELECT_RESET;
      rdata_q                 <= 8'h00;
    end else begin
      clock_divider_select_q  <= clock_divider_select_d;
      quick_wake_enable_q     <= quick_wake_enable_d;
      idle_on_halt_q          <= idle_on_halt_d;
      high_low_clock_select_q <= high_low_clock_select_d;
      rdata_q                 <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // -----------------------------------------------------------------
  // System clock source and divider
  // -----------------------------------------------------------------
  logic       sel_fast;
  logic [5:0] div_cnt_q, div_cnt_d;
  logic [5:0] div_mask;
  logic [3:0] div_shift;
  logic       div_tick;
  logic       src_tick;
  logic       src_ready;

  assign sel_fast  = high_low_clock_select_q ||
                     (clock_divider_select_q >= pmcs_pkg::CKS_FIRST_DIV);
  // Code 010 divides by 64, each step up halves the ratio
  assign div_shift = pmcs_pkg::CKS_SHIFT_TOP - {1'b0, clock_divider_select_q};
  assign div_mask  = 6'(({6'h00, 1'b1} << div_shift) - 7'h01);

  always_comb begin
    div_cnt_d = div_cnt_q;
    if (fast_osc_tick) begin
      div_cnt_d = div_cnt_q + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt_q <= 6'h00;
    end else begin
      div_cnt_q <= div_cnt_d;
    end
  end

  assign div_tick = fast_osc_tick && ((div_cnt_q & div_mask) == div_mask);

  always_comb begin
    if (high_low_clock_select_q) begin
      src_tick = fast_osc_tick;
    end else if (sel_fast) begin
      src_tick = div_tick;
    end else begin
      src_tick = slow_osc_tick;
    end
  end

  // -----------------------------------------------------------------
  // Power state machine
  // -----------------------------------------------------------------
  pmcs_pkg::pmcs_state_e state_q, state_d;
  logic                  light_keep_slow;
  logic                  quick_ok;

  // Slow clocks kept in light sleep
  assign light_keep_slow = low_voltage_detect_enable || (cfg_wdt_enable && cfg_wdt_on_slow);
  assign quick_ok = quick_wake_enable_q && cfg_fast_is_crystal && sel_fast;
  assign src_ready = sel_fast ? fast_osc_ready : slow_osc_ready;

  always_comb begin
    state_d = state_q;
    case (state_q)
      pmcs_pkg::ST_RUN: begin
        if (halt_req) begin
          if (!idle_on_halt_q) begin
            if (low_voltage_detect_enable || cfg_wdt_enable) begin
              state_d = pmcs_pkg::ST_LIGHT;
            end else begin
              state_d = pmcs_pkg::ST_DEEP;
            end
          end else if (system_osc_keep_on) begin
            state_d = pmcs_pkg::ST_IDLE_FULL;
          end else begin
            state_d = pmcs_pkg::ST_IDLE_LOW;
          end
        end
      end
      pmcs_pkg::ST_DEEP: begin
        if (wake_req) begin
          state_d = pmcs_pkg::ST_WAKE;
        end
      end
      // Quick wake from light, low idle
      pmcs_pkg::ST_LIGHT: begin
        if (wake_req) begin
          state_d = (quick_ok && light_keep_slow) ? pmcs_pkg::ST_QUICK : pmcs_pkg::ST_WAKE;
        end
      end
      pmcs_pkg::ST_IDLE_LOW: begin
        if (wake_req) begin
          state_d = quick_ok ? pmcs_pkg::ST_QUICK : pmcs_pkg::ST_WAKE;
        end
      end
      pmcs_pkg::ST_IDLE_FULL: begin
        if (wake_req) begin
          state_d = pmcs_pkg::ST_WAKE;
        end
      end
      pmcs_pkg::ST_WAKE: begin
        if (src_ready && src_tick) begin
          state_d = pmcs_pkg::ST_RUN;
        end
      end
      pmcs_pkg::ST_QUICK: begin
        if (fast_osc_ready) begin
          state_d = pmcs_pkg::ST_RUN;
        end
      end
      default: state_d = pmcs_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= pmcs_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // -----------------------------------------------------------------
  // Clock gating per state
  // -----------------------------------------------------------------
  always_comb begin
    fast_osc_enable = 1'b0;
    slow_osc_enable = 1'b1;
    wdt_run         = cfg_wdt_enable;
    cpu_run         = 1'b0;
    sys_clk_tick    = 1'b0;
    case (state_q)
      pmcs_pkg::ST_RUN: begin
        // Fast oscillator off on slow source
        fast_osc_enable = sel_fast;
        cpu_run         = 1'b1;
        sys_clk_tick    = src_tick;
      end
      pmcs_pkg::ST_DEEP: begin
        slow_osc_enable = 1'b0;
        wdt_run         = 1'b0;
      end
      pmcs_pkg::ST_LIGHT: begin
        slow_osc_enable = light_keep_slow;
      end
      pmcs_pkg::ST_IDLE_LOW: begin
        fast_osc_enable = 1'b0;
      end
      pmcs_pkg::ST_IDLE_FULL: begin
        fast_osc_enable = sel_fast;
        sys_clk_tick    = src_tick;
      end
      pmcs_pkg::ST_WAKE: begin
        fast_osc_enable = sel_fast;
      end
      pmcs_pkg::ST_QUICK: begin
        // Stable slow clock stands in while the crystal settles
        fast_osc_enable = 1'b1;
        cpu_run         = slow_osc_ready;
        sys_clk_tick    = slow_osc_tick && slow_osc_ready;
      end
      default: begin
        fast_osc_enable = 1'b1;
      end
    endcase
  end

  assign slow_periph_clk_enable = slow_osc_enable;
  assign power_state            = state_q;

  // -----------------------------------------------------------------
  // Oscillator ready flags
  // -----------------------------------------------------------------
  logic [CNT_W-1:0] fast_target;
  logic [CNT_W-1:0] slow_target;

  assign fast_target = cfg_fast_is_crystal ? CNT_W'(FAST_XTAL_CN) : CNT_W'(FAST_RC_CN);
  assign slow_target = cfg_slow_is_crystal ? CNT_W'(SLOW_XTAL_CN) : CNT_W'(SLOW_RC_CN);

  pmcs_stab_cnt #(.CNT_W(CNT_W)) u_fast_rdy (
    .clk      (clk),
    .rst      (rst),
    .osc_on   (fast_osc_enable),
    .osc_tick (fast_osc_tick),
    .target   (fast_target),
    .ready    (fast_osc_ready)
  );

  pmcs_stab_cnt #(.CNT_W(CNT_W)) u_slow_rdy (
    .clk      (clk),
    .rst      (rst),
    .osc_on   (slow_osc_enable),
    .osc_tick (slow_osc_tick),
    .target   (slow_target),
    .ready    (slow_osc_ready)
  );

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_halt_to_sleep: assert property (
    state_q == pmcs_pkg::ST_RUN && halt_req && !idle_on_halt_q |=>
      state_q inside {pmcs_pkg::ST_DEEP, pmcs_pkg::ST_LIGHT})
    else $error("halt with idle bit low did not sleep");
  a_deep_all_off: assert property (
    state_q == pmcs_pkg::ST_DEEP |->
      !slow_osc_enable && !slow_periph_clk_enable && !wdt_run && !cpu_run)
    else $error("clock left running in deep sleep");
  a_lvd_no_deep: assert property (
    state_q == pmcs_pkg::ST_RUN && halt_req && low_voltage_detect_enable |=>
      state_q != pmcs_pkg::ST_DEEP)
    else $error("deep sleep entered with detector on");
  a_light_keeps_slow: assert property (
    state_q == pmcs_pkg::ST_LIGHT && low_voltage_detect_enable |-> slow_osc_enable)
    else $error("slow clock stopped in light sleep");
  a_idle_low_clk: assert property (
    state_q == pmcs_pkg::ST_IDLE_LOW |-> !fast_osc_enable && wdt_run == cfg_wdt_enable)
    else $error("low idle clocking wrong");
  a_idle_full_clk: assert property (
    state_q == pmcs_pkg::ST_IDLE_FULL |-> fast_osc_enable == sel_fast && !cpu_run)
    else $error("full idle clocking wrong");
  a_div_tick_src: assert property (
    state_q == pmcs_pkg::ST_RUN && !high_low_clock_select_q && sel_fast && sys_clk_tick |->
      fast_osc_tick && (div_cnt_q & div_mask) == div_mask)
    else $error("divided tick off its phase");
  a_undivided_fast: assert property (
    state_q == pmcs_pkg::ST_RUN && high_low_clock_select_q |-> sys_clk_tick == fast_osc_tick)
    else $error("undivided clock not passed through");
  a_fast_off_slow: assert property (
    state_q == pmcs_pkg::ST_RUN && !sel_fast |-> !fast_osc_enable)
    else $error("fast oscillator left on in slow mode");
  a_slow_rdy_deep: assert property (
    state_q == pmcs_pkg::ST_DEEP && $past(state_q) == pmcs_pkg::ST_DEEP |-> !slow_osc_ready)
    else $error("slow ready high in deep sleep");
  a_fast_rdy_stop: assert property (
    !fast_osc_enable |=> !fast_osc_ready)
    else $error("fast ready high with oscillator stopped");
  a_deep_no_quick: assert property (
    state_q == pmcs_pkg::ST_DEEP && wake_req |=> state_q == pmcs_pkg::ST_WAKE)
    else $error("quick wake taken from deep sleep");
  a_quick_handover: assert property (
    state_q == pmcs_pkg::ST_QUICK && fast_osc_ready |=> state_q == pmcs_pkg::ST_RUN)
    else $error("quick wake did not hand over");

  c_deep_cycle: cover property (
    state_q == pmcs_pkg::ST_DEEP ##[1:20] state_q == pmcs_pkg::ST_RUN);
  c_quick_wake: cover property (
    state_q == pmcs_pkg::ST_QUICK ##[1:300] state_q == pmcs_pkg::ST_RUN);
  c_full_idle: cover property (
    state_q == pmcs_pkg::ST_IDLE_FULL ##[1:20] state_q == pmcs_pkg::ST_RUN);

endmodule

// ### dv/tb_top.sv
`timescale 1ns/10ps
`define CHK(name, exp, got) \
  begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("FAIL %s expected %h seen %h", name, exp, got); end end
module tb_top;
  // ---------------------------------------------
  // Clock, reset and design
  // ---------------------------------------------
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       halt_req = 1'b0;
  logic       wake_req = 1'b0;
  logic       low_voltage_detect_enable = 1'b0;
  logic       system_osc_keep_on = 1'b0;
  logic       cfg_fast_is_crystal = 1'b1;
  logic       cfg_slow_is_crystal = 1'b1;
  logic       cfg_wdt_enable = 1'b0;
  logic       cfg_wdt_on_slow = 1'b1;
  logic       fast_osc_tick = 1'b0;
  logic       slow_osc_tick = 1'b0;
  logic       fast_osc_enable;
  logic       slow_osc_enable;
  logic       slow_periph_clk_enable;
  logic       wdt_run;
  logic       cpu_run;
  logic       sys_clk_tick;
  logic [2:0] power_state;
  logic       ticks_on = 1'b0;
  logic [2:0] ph = 3'h0;
  int         n_errors = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  always #5 clk = ~clk;

  pmcs_top #(.FAST_XTAL_CN(4), .SLOW_XTAL_CN(4)) u_pmcs_top (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .halt_req(halt_req), .wake_req(wake_req),
    .low_voltage_detect_enable(low_voltage_detect_enable),
    .system_osc_keep_on(system_osc_keep_on),
    .cfg_fast_is_crystal(cfg_fast_is_crystal),
    .cfg_slow_is_crystal(cfg_slow_is_crystal),
    .cfg_wdt_enable(cfg_wdt_enable), .cfg_wdt_on_slow(cfg_wdt_on_slow),
    .fast_osc_tick(fast_osc_tick), .slow_osc_tick(slow_osc_tick),
    .fast_osc_enable(fast_osc_enable), .slow_osc_enable(slow_osc_enable),
    .slow_periph_clk_enable(slow_periph_clk_enable), .wdt_run(wdt_run),
    .cpu_run(cpu_run), .sys_clk_tick(sys_clk_tick), .power_state(power_state));

  // ---------------------------------------------
  // Oscillators: tick only while enabled
  // ---------------------------------------------
  always @(posedge clk) begin
    ph <= ph + 3'h1;
    fast_osc_tick <= ticks_on && fast_osc_enable && ph[0];
    slow_osc_tick <= ticks_on && slow_osc_enable && (ph == 3'h7);
  end

  // ---------------------------------------------
  // Bus and control tasks
  // ---------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic cfg(input logic lvd, input logic wdt, input logic keep);
    @(posedge clk);
    low_voltage_detect_enable <= lvd; cfg_wdt_enable <= wdt; system_osc_keep_on <= keep;
  endtask

  task automatic halt_pulse();
    @(posedge clk); halt_req <= 1'b1;
    @(posedge clk); halt_req <= 1'b0;
    #1;
  endtask

  task automatic wake_pulse();
    @(posedge clk); wake_req <= 1'b1;
    @(posedge clk); wake_req <= 1'b0;
    #1;
  endtask

  task automatic wait_run(input int lim, output int n);
    n = 0;
    while (power_state !== 3'h0 && n < lim) begin @(posedge clk); #1; n++; end
  endtask

  task automatic count_ticks(output int c);
    c = 0;
    repeat (128) begin @(posedge clk); #1; if (sys_clk_tick === 1'b1) c++; end
  endtask

  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_reset_regs();
    logic [7:0] d;
    rd(4'h0, d);
    `CHK("reset value", 8'h03, d)
    wr(4'h0, 8'hff);
    rd(4'h0, d);
    `CHK("ready bits read only", 8'hf3, d)
    rd(4'h5, d);
    `CHK("unmapped read", 8'h00, d)
    wr(4'h0, 8'h03);
    ticks_on <= 1'b1;
    repeat (60) @(posedge clk);
  endtask

  task automatic t_deep(input logic quick);
    logic [7:0] d;
    int n;
    cfg(1'b0, 1'b0, 1'b0);
    wr(4'h0, {3'h0, quick, 4'h1});
    halt_pulse();
    `CHK("deep state", 3'h1, power_state)
    `CHK("deep slow osc", 1'b0, slow_osc_enable)
    `CHK("deep periph clk", 1'b0, slow_periph_clk_enable)
    `CHK("deep wdt", 1'b0, wdt_run)
    `CHK("deep cpu", 1'b0, cpu_run)
    rd(4'h0, d);
    `CHK("slow ready in deep", 1'b0, d[3])
    wake_pulse();
    `CHK("deep wake state", 3'h5, power_state)
    wait_run(2000, n);
    `CHK("deep back to run", 1'b1, cpu_run)
    rd(4'h0, d);
    `CHK("fast ready after wake", 1'b1, d[2])
  endtask

  task automatic t_light();
    int n;
    for (int k = 0; k < 2; k++) begin
      cfg(k == 0, k == 1, 1'b0);
      wr(4'h0, 8'h01);
      halt_pulse();
      `CHK("light state", 3'h2, power_state)
      `CHK("light slow osc", 1'b1, slow_osc_enable)
      `CHK("light periph clk", 1'b1, slow_periph_clk_enable)
      `CHK("light cpu", 1'b0, cpu_run)
      wake_pulse();
      wait_run(2000, n);
      `CHK("light back to run", 3'h0, power_state)
    end
  endtask

  task automatic t_idle();
    logic [7:0] d;
    int n;
    cfg(1'b0, 1'b1, 1'b0);
    wr(4'h0, 8'h03);
    halt_pulse();
    `CHK("low idle state", 3'h3, power_state)
    `CHK("low idle fast osc", 1'b0, fast_osc_enable)
    `CHK("low idle wdt", 1'b1, wdt_run)
    rd(4'h0, d);
    `CHK("fast ready low idle", 1'b0, d[2])
    wake_pulse();
    wait_run(2000, n);
    cfg(1'b0, 1'b1, 1'b1);
    halt_pulse();
    `CHK("full idle state", 3'h4, power_state)
    `CHK("full idle fast osc", 1'b1, fast_osc_enable)
    `CHK("full idle cpu", 1'b0, cpu_run)
    wake_pulse();
    wait_run(8, n);
    `CHK("full idle quick return", 3'h0, power_state)
  endtask

  task automatic t_quick();
    logic [7:0] d;
    int n;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) cfg_fast_is_crystal <= (k == 0);
      cfg(1'b0, 1'b1, 1'b0);
      wr(4'h0, 8'h11);
      repeat (60) @(posedge clk);
      halt_pulse();
      wake_pulse();
      `CHK("quick wake state", (k == 0) ? 3'h6 : 3'h5, power_state)
      wait_run(2000, n);
      rd(4'h0, d);
      `CHK("fast ready after quick", 1'b1, d[2])
    end
    @(posedge clk) cfg_fast_is_crystal <= 1'b1;
  endtask

  task automatic t_divider();
    int c;
    for (int code = 7; code >= 2; code--) begin
      wr(4'h0, {code[2:0], 5'h02});
      repeat (20) @(posedge clk);
      count_ticks(c);
      `CHK("divided ticks", 64 >> (8 - code), c)
    end
    wr(4'h0, 8'h03);
    repeat (20) @(posedge clk);
    count_ticks(c);
    `CHK("undivided ticks", 64, c)
    wr(4'h0, 8'h22);
    repeat (40) @(posedge clk);
    `CHK("fast osc off on slow", 1'b0, fast_osc_enable)
    count_ticks(c);
    `CHK("slow clock ticks", 16, c)
  endtask

  // ---------------------------------------------
  // Sequence, timeout and verdict
  // ---------------------------------------------
  task automatic end_of_test();
    $display("n_errors=%0d samples_checked=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Whole run needs under two thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      end_of_test();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset_regs();
    t_deep(1'b0);
    t_deep(1'b1);
    t_light();
    t_idle();
    t_quick();
    t_divider();
    end_of_test();
  end
endmodule
